// File: pkg/ack_ctrl_pkg.sv
// Shared constants and types for the latch acknowledge controller
package ack_ctrl_pkg;
    // Clock rate in Hz
    localparam int unsigned CLK_HZ = 25000000;
    // Long-press hold, ms
    localparam int unsigned LONG_PRESS_MS = 1000;
    // Long-press hold in cycles
    localparam int unsigned LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
    // LED test phase, ms
    localparam int unsigned LED_PHASE_MS = 1000;
    // LED test phase in cycles
    localparam int unsigned LED_PHASE_CYC = (CLK_HZ / 1000) * LED_PHASE_MS;
    // Counter width for both timers
    localparam int unsigned TIMER_W = 26;

    // Long-press scope setting codes
    typedef enum logic [2:0]
    {
        SCOPE_NOTHING = 3'h0,
        SCOPE_LEDS_NO_PASSWORD = 3'h1,
        SCOPE_LEDS = 3'h2,
        SCOPE_LEDS_RELAYS = 3'h3,
        SCOPE_EVERYTHING = 3'h4
    } scope_e;
    // Scope value after reset
    localparam logic [2:0] SCOPE_RESET = 3'h1;

    // Category bit positions
    localparam int unsigned CAT_LED = 0;
    localparam int unsigned CAT_RELAY = 1;
    localparam int unsigned CAT_SCADA = 2;
    localparam int unsigned CAT_TRIP = 3;
    localparam int unsigned CAT_W = 4;
endpackage : ack_ctrl_pkg

// File: design/clear_key_timer.sv
// Clear-key hold timer separating short and long presses
`timescale 1ns/10ps
`default_nettype none
module clear_key_timer #(
    parameter int unsigned HOLD_CYC = ack_ctrl_pkg::LONG_PRESS_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic keyDown,
    output logic shortPress,
    output logic longPress
);
    // Counter cannot serve a zero or oversized threshold
    initial
    begin
        if (HOLD_CYC < 1 || HOLD_CYC >= (1 << ack_ctrl_pkg::TIMER_W))
        begin
            $error("HOLD_CYC out of range");
        end
    end

    // Hold count, saturates at threshold
    logic [ack_ctrl_pkg::TIMER_W-1:0] holdCnt_r;
    // Long press already reported for this hold
    logic longDone_r;
    logic keyPrev_r;
    localparam logic [ack_ctrl_pkg::TIMER_W-1:0] LAST = ack_ctrl_pkg::TIMER_W'(HOLD_CYC - 1);

    // Count held cycles; restart on release
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            holdCnt_r <= '0;
            longDone_r <= 1'b0;
            keyPrev_r <= 1'b0;
        end
        else
        begin
            keyPrev_r <= keyDown;
            if (!keyDown)
            begin
                holdCnt_r <= '0;
                longDone_r <= 1'b0;
            end
            else if (holdCnt_r == LAST)
            begin
                // One long press per hold
                longDone_r <= 1'b1;
            end
            else
            begin
                holdCnt_r <= holdCnt_r + 1'b1;
            end
        end
    end

    // Pulses; release before threshold is short
    assign longPress = keyDown && (holdCnt_r == LAST) && !longDone_r;
    assign shortPress = keyPrev_r && !keyDown && !longDone_r;
endmodule : clear_key_timer
`default_nettype wire

// File: design/led_test_seq.sv
// LED test sequencer: red phase then green phase
`timescale 1ns/10ps
`default_nettype none
module led_test_seq #(
    parameter int unsigned PHASE_CYC = ack_ctrl_pkg::LED_PHASE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    output logic testRed,
    output logic testGreen
);
    // Reject thresholds the counter cannot hold
    initial
    begin
        if (PHASE_CYC < 1 || PHASE_CYC >= (1 << ack_ctrl_pkg::TIMER_W))
        begin
            $error("PHASE_CYC out of range");
        end
    end

    typedef enum logic [1:0]
    {
        T_IDLE = 2'b00,
        T_RED = 2'b01,
        T_GREEN = 2'b10
    } test_e;
    test_e st_r;
    logic [ack_ctrl_pkg::TIMER_W-1:0] cnt_r;
    localparam logic [ack_ctrl_pkg::TIMER_W-1:0] LAST = ack_ctrl_pkg::TIMER_W'(PHASE_CYC - 1);

    // Phase sequencing; a new start restarts the test
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= T_IDLE;
            cnt_r <= '0;
        end
        else if (start)
        begin
            st_r <= T_RED;
            cnt_r <= '0;
        end
        else
        begin
            case (st_r)
                T_RED:
                begin
                    cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
                    if (cnt_r == LAST)
                    begin
                        st_r <= T_GREEN;
                    end
                end
                T_GREEN:
                begin
                    cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
                    if (cnt_r == LAST)
                    begin
                        st_r <= T_IDLE;
                    end
                end
                default:
                begin
                    cnt_r <= '0;
                end
            endcase
        end
    end

    // Colour flags decoded from the phase state register
    assign testRed = (st_r == T_RED);
    assign testGreen = (st_r == T_GREEN);
endmodule : led_test_seq
`default_nettype wire

// File: design/latch_acknowledge_controller.sv
// Latch acknowledge controller: clears latched LEDs, relays, SCADA and trips
`timescale 1ns/10ps
`default_nettype none
module latch_acknowledge_controller #(
    parameter int unsigned N_LED = 14,
    parameter int unsigned N_RELAY = 8,
    parameter int unsigned N_SCADA = 8,
    parameter int unsigned N_SG = 6,
    parameter int unsigned HOLD_CYC = ack_ctrl_pkg::LONG_PRESS_CYC,
    parameter int unsigned PHASE_CYC = ack_ctrl_pkg::LED_PHASE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clearKey,
    input wire logic paramSetMode,
    input wire logic menuOpenNav,
    input wire logic [3:0] softkeySelect,
    input wire logic softkeyConfirm,
    input wire logic softkeyCancel,
    input wire logic scopeWrite,
    input wire logic [2:0] scopeValue,
    input wire logic passwordValid,
    input wire logic first_protection_access_level_empty,
    input wire logic remotePermit,
    input wire logic clear_all_latched_cmd,
    input wire logic switchgear_trip_clear_cmd,
    input wire logic [7:0] switchgearSel,
    input wire logic remoteLedClear,
    input wire logic remoteRelayClear,
    input wire logic remoteScadaClear,
    input wire logic [N_LED-1:0] ledSet,
    input wire logic [N_RELAY-1:0] relaySet,
    input wire logic [N_SCADA-1:0] scadaSet,
    input wire logic [N_SG-1:0] tripSet,
    input wire logic [N_RELAY-1:0] relayOffDelayDone,
    output logic [N_LED-1:0] ledLatched,
    output logic [N_RELAY-1:0] relayLatched,
    output logic [N_SCADA-1:0] scadaLatched,
    output logic [N_SG-1:0] tripPending,
    output logic menuActive,
    output logic passwordRequest,
    output logic [2:0] scopeSetting,
    output logic ledClearPulse,
    output logic relayClearPulse,
    output logic scadaClearPulse,
    output logic tripClearPulse,
    output logic ledTestRed,
    output logic ledTestGreen
);
    // Widths the selector and latches can serve
    initial
    begin
        if (N_LED < 1 || N_RELAY < 1 || N_SCADA < 1 || N_SG < 1 || N_SG > 256)
        begin
            $error("bad instance counts");
        end
    end

    localparam int unsigned CL = ack_ctrl_pkg::CAT_LED;
    localparam int unsigned CR = ack_ctrl_pkg::CAT_RELAY;
    localparam int unsigned CS = ack_ctrl_pkg::CAT_SCADA;
    localparam int unsigned CT = ack_ctrl_pkg::CAT_TRIP;

    // Long-press scope to category mask
    function automatic logic [3:0] scopeCats(input logic [2:0] s);
        logic [3:0] m;
        m = 4'h0;
        if (s == ack_ctrl_pkg::SCOPE_LEDS_NO_PASSWORD || s == ack_ctrl_pkg::SCOPE_LEDS)
        begin
            m[CL] = 1'b1;
        end
        else if (s == ack_ctrl_pkg::SCOPE_LEDS_RELAYS)
        begin
            m[CL] = 1'b1;
            m[CR] = 1'b1;
        end
        else if (s == ack_ctrl_pkg::SCOPE_EVERYTHING)
        begin
            m = 4'hF;
        end
        return m;
    endfunction : scopeCats

    // Password needed for these categories
    function automatic logic needsPw(input logic [3:0] cats, input logic lvlEmpty);
        logic other;
        other = cats[CR] | cats[CS] | cats[CT];
        // Empty first level waives relay, SCADA and trip checks
        return cats[CL] | (other & !lvlEmpty);
    endfunction : needsPw

    // Key timing
    logic shortPress;
    logic longPress;
    clear_key_timer #(.HOLD_CYC(HOLD_CYC)) uKey (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .keyDown(clearKey && !paramSetMode),
        .shortPress(shortPress),
        .longPress(longPress)
    );

    // Scope setting register
    logic [2:0] scope_r;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scope_r <= ack_ctrl_pkg::SCOPE_RESET;
        end
        else if (scopeWrite && scopeValue <= 3'h4)
        begin
            scope_r <= scopeValue;
        end
    end
    assign scopeSetting = scope_r;

    // Panel state: menu and pending password wait
    typedef enum logic [1:0]
    {
        P_IDLE = 2'b00,
        P_MENU = 2'b01,
        P_PASSWORD = 2'b10
    } panel_e;
    panel_e pst_r;
    // Softkey-picked categories in the menu
    logic [3:0] menuSel_r;
    // Categories awaiting password
    logic [3:0] pendCats_r;

    // Panel requests this cycle
    logic [3:0] longCats;
    logic longFire;
    logic [3:0] confirmCats;
    logic [3:0] panelGo;
    always_comb
    begin
        longCats = scopeCats(scope_r);
        // Scope nothing yields empty mask, long press ignored
        longFire = longPress && (longCats != 4'h0);
        confirmCats = menuSel_r | softkeySelect;
        panelGo = 4'h0;
        if (pst_r == P_PASSWORD && passwordValid)
        begin
            panelGo = pendCats_r;
        end
        else if (pst_r != P_PASSWORD && longFire
                 && !(needsPw(longCats, first_protection_access_level_empty)
                      && scope_r != ack_ctrl_pkg::SCOPE_LEDS_NO_PASSWORD))
        begin
            panelGo = longCats;
        end
        else if (pst_r == P_MENU && softkeyConfirm
                 && !needsPw(confirmCats, first_protection_access_level_empty))
        begin
            panelGo = confirmCats;
        end
    end

    // Panel state machine
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pst_r <= P_IDLE;
            menuSel_r <= 4'h0;
            pendCats_r <= 4'h0;
        end
        else
        begin
            case (pst_r)
                P_IDLE:
                begin
                    menuSel_r <= 4'h0;
                    if (longFire && panelGo == 4'h0)
                    begin
                        // Long press needing password
                        pendCats_r <= longCats;
                        pst_r <= P_PASSWORD;
                    end
                    else if (shortPress || menuOpenNav)
                    begin
                        pst_r <= P_MENU;
                    end
                end
                P_MENU:
                begin
                    menuSel_r <= confirmCats;
                    if (softkeyCancel)
                    begin
                        pst_r <= P_IDLE;
                    end
                    else if (longFire && panelGo == longCats)
                    begin
                        pst_r <= P_IDLE;
                    end
                    else if (longFire)
                    begin
                        pendCats_r <= longCats;
                        pst_r <= P_PASSWORD;
                    end
                    else if (softkeyConfirm && confirmCats != 4'h0)
                    begin
                        pendCats_r <= confirmCats;
                        pst_r <= (panelGo != 4'h0) ? P_IDLE : P_PASSWORD;
                    end
                end
                P_PASSWORD:
                begin
                    if (passwordValid || softkeyCancel)
                    begin
                        pst_r <= P_IDLE;
                    end
                end
                default:
                begin
                    pst_r <= P_IDLE;
                end
            endcase
        end
    end
    assign menuActive = (pst_r == P_MENU);
    assign passwordRequest = (pst_r == P_PASSWORD);

    // Remote sources need permit
    logic [3:0] remoteCats;
    logic sgHit;
    always_comb
    begin
        remoteCats = 4'h0;
        if (remotePermit)
        begin
            remoteCats[CL] = remoteLedClear | clear_all_latched_cmd;
            remoteCats[CR] = remoteRelayClear | clear_all_latched_cmd;
            remoteCats[CS] = remoteScadaClear | clear_all_latched_cmd;
            remoteCats[CT] = clear_all_latched_cmd;
        end
        sgHit = remotePermit && switchgear_trip_clear_cmd;
    end

    // Accepted categories this cycle
    logic [3:0] go;
    assign go = panelGo | remoteCats;

    // Selected switchgear one-hot
    logic [N_SG-1:0] sgMask;
    always_comb
    begin
        sgMask = '0;
        for (int i = 0; i < N_SG; i++)
        begin
            sgMask[i] = sgHit && (switchgearSel == 8'(i));
        end
    end

    // Latches: set wins
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ledLatched <= '0;
            relayLatched <= '0;
            scadaLatched <= '0;
            tripPending <= '0;
        end
        else
        begin
            ledLatched <= ledSet | (ledLatched & ~({N_LED{go[CL]}}));
            // Relay clears act only on relays whose off-delay is done; others stay latched
            relayLatched <= relaySet
                | (relayLatched & ~({N_RELAY{go[CR]}} & relayOffDelayDone));
            scadaLatched <= scadaSet | (scadaLatched & ~({N_SCADA{go[CS]}}));
            tripPending <= tripSet | (tripPending & ~({N_SG{go[CT]}} | sgMask));
        end
    end

    // Per-category pulses, one cycle
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ledClearPulse <= 1'b0;
            relayClearPulse <= 1'b0;
            scadaClearPulse <= 1'b0;
            tripClearPulse <= 1'b0;
        end
        else
        begin
            ledClearPulse <= go[CL];
            relayClearPulse <= go[CR];
            scadaClearPulse <= go[CS];
            tripClearPulse <= go[CT] | (|sgMask);
        end
    end

    // LED test after any LED clear
    led_test_seq #(.PHASE_CYC(PHASE_CYC)) uTest (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(go[CL]),
        .testRed(ledTestRed),
        .testGreen(ledTestGreen)
    );
endmodule : latch_acknowledge_controller
`default_nettype wire

// File: verification/ack_ctrl_props.sv
// Port-level assertions for the latch acknowledge controller
`timescale 1ns/10ps
`default_nettype none
module ack_ctrl_props #(
    parameter int unsigned N_LED = 14,
    parameter int unsigned N_RELAY = 8,
    parameter int unsigned N_SG = 6,
    parameter int unsigned PHASE_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [N_LED-1:0] ledSet,
    input wire logic [N_RELAY-1:0] relayOffDelayDone,
    input wire logic scopeWrite,
    input wire logic [2:0] scopeValue,
    input wire logic [N_LED-1:0] ledLatched,
    input wire logic [N_RELAY-1:0] relayLatched,
    input wire logic [N_SG-1:0] tripPending,
    input wire logic [2:0] scopeSetting,
    input wire logic ledClearPulse,
    input wire logic relayClearPulse,
    input wire logic scadaClearPulse,
    input wire logic tripClearPulse,
    input wire logic ledTestRed,
    input wire logic ledTestGreen
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Any clear pulse
    wire logic anyPulse = ledClearPulse | relayClearPulse | scadaClearPulse | tripClearPulse;
    // Colour run lengths; counters avoid long repetitions
    int unsigned redRun_r;
    int unsigned greenRun_r;

    // Colour run counters
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            redRun_r <= 0;
            greenRun_r <= 0;
        end
        else
        begin
            redRun_r <= ledTestRed ? redRun_r + 1 : 0;
            greenRun_r <= ledTestGreen ? greenRun_r + 1 : 0;
        end
    end

    // Red to green
    sequence s_redEnd;
        ledTestRed ##1 (ledTestGreen && !ledTestRed);
    endsequence
    // Green to off
    sequence s_greenEnd;
        ledTestGreen ##1 (!ledTestGreen && !ledTestRed);
    endsequence

    a_pulse_single: assert property (anyPulse |=> !anyPulse)
        else $error("pulse longer than one cycle");
    a_led_fall_pulse: assert property (|($past(ledLatched) & ~ledLatched) |-> ledClearPulse)
        else $error("LED drop without pulse");
    a_trip_fall_pulse: assert property (|($past(tripPending) & ~tripPending) |-> tripClearPulse)
        else $error("trip drop without pulse");
    a_led_set_wins: assert property (ledClearPulse |-> ($past(ledSet) & ~ledLatched) == '0)
        else $error("LED cleared while source active");
    a_led_cleared: assert property (ledClearPulse |-> (ledLatched & ~$past(ledSet)) == '0)
        else $error("LED latch survived clear");
    a_relay_fall_ok: assert property (|($past(relayLatched) & ~relayLatched) |->
        relayClearPulse && ($past(relayLatched) & ~relayLatched & ~$past(relayOffDelayDone)) == '0)
        else $error("relay released early");
    a_scope_reset: assert property ($rose(reset_n) |-> scopeSetting == 3'h1)
        else $error("bad scope reset");
    a_scope_write: assert property (scopeWrite && scopeValue <= 3'h4 |=> scopeSetting == $past(scopeValue))
        else $error("scope not written");
    a_scope_keep: assert property (!(scopeWrite && scopeValue <= 3'h4) |=> $stable(scopeSetting))
        else $error("scope changed unasked");
    a_test_start: assert property (ledClearPulse |-> ledTestRed && !ledTestGreen)
        else $error("LED test not started");
    a_red_length: assert property (s_redEnd |-> redRun_r == PHASE_CYC)
        else $error("bad red length");
    a_green_length: assert property (s_greenEnd |-> greenRun_r == PHASE_CYC)
        else $error("bad green length");
endmodule : ack_ctrl_props
bind latch_acknowledge_controller ack_ctrl_props #(.N_LED(N_LED), .N_RELAY(N_RELAY), .N_SG(N_SG),
    .PHASE_CYC(PHASE_CYC)) props_u (.clk_sys, .reset_n, .ledSet, .relayOffDelayDone, .scopeWrite,
    .scopeValue, .ledLatched, .relayLatched, .tripPending, .scopeSetting, .ledClearPulse,
    .relayClearPulse, .scadaClearPulse, .tripClearPulse, .ledTestRed, .ledTestGreen);
`default_nettype wire

// File: verification/front_panel_model.sv
// Panel clear key and relay off-delay timers facing the controller
`timescale 1ns/10ps
`default_nettype none
module front_panel_model #(
    parameter int unsigned N_RELAY = 8,
    parameter int unsigned OFF_CYC = 3
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic pressGo,
    input wire logic [7:0] pressLen,
    input wire logic [N_RELAY-1:0] relaySet,
    output logic clearKey,
    output logic [N_RELAY-1:0] relayOffDelayDone
);
    // Key hold cycles left
    logic [7:0] holdCnt_r;
    // Off-delay counters, one per relay
    logic [3:0] offCnt_r [N_RELAY];

    // Key held for commanded count
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            holdCnt_r <= 8'h00;
        else if (pressGo)
            holdCnt_r <= pressLen;
        else if (holdCnt_r != 8'h00)
            holdCnt_r <= holdCnt_r - 8'h01;
    end
    assign clearKey = (holdCnt_r != 8'h00);

    // Off-delay restarts while source active
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        for (int i = 0; i < N_RELAY; i++)
        begin
            if (!reset_n || relaySet[i])
                offCnt_r[i] <= 4'h0;
            else if (offCnt_r[i] < 4'(OFF_CYC))
                offCnt_r[i] <= offCnt_r[i] + 4'h1;
        end
    end

    // Expired after full delay
    always_comb
    begin
        for (int i = 0; i < N_RELAY; i++)
            relayOffDelayDone[i] = !relaySet[i] && offCnt_r[i] >= 4'(OFF_CYC);
    end
endmodule : front_panel_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the latch acknowledge controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int unsigned HOLD = 8;
    localparam int unsigned PHASE = 4;
    localparam int unsigned OFF = 3;
    // Expected pulses and latches
    typedef struct packed
    {
        logic [3:0] pul;
        logic [13:0] led;
        logic [7:0] rel;
        logic [7:0] scd;
        logic [5:0] trp;
    } note_s;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic paramSetMode, menuOpenNav, softkeyConfirm, softkeyCancel, scopeWrite, pressGo;
    logic passwordValid, first_protection_access_level_empty, remotePermit, clearKey;
    logic clear_all_latched_cmd, switchgear_trip_clear_cmd, menuActive, passwordRequest;
    logic remoteLedClear, remoteRelayClear, remoteScadaClear, ledTestRed, ledTestGreen;
    logic ledClearPulse, relayClearPulse, scadaClearPulse, tripClearPulse;
    logic [3:0] softkeySelect;
    logic [2:0] scopeValue, scopeSetting;
    logic [7:0] switchgearSel, pressLen, relaySet, scadaSet, relayOffDelayDone;
    logic [7:0] relayLatched, scadaLatched;
    logic [13:0] ledSet, ledLatched;
    logic [5:0] tripSet, tripPending;
    logic [31:0] rnd;
    // Long-press scope categories
    logic [3:0] msk [5] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'hF};
    note_s noteQ [$];
    note_s st;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'hCF9C;

    latch_acknowledge_controller #(.HOLD_CYC(HOLD), .PHASE_CYC(PHASE)) dut_u (.clk_sys, .reset_n,
        .clearKey, .paramSetMode, .menuOpenNav, .softkeySelect, .softkeyConfirm, .softkeyCancel,
        .scopeWrite, .scopeValue, .passwordValid, .first_protection_access_level_empty,
        .remotePermit, .clear_all_latched_cmd, .switchgear_trip_clear_cmd, .switchgearSel,
        .remoteLedClear, .remoteRelayClear, .remoteScadaClear, .ledSet, .relaySet, .scadaSet,
        .tripSet, .relayOffDelayDone, .ledLatched, .relayLatched, .scadaLatched, .tripPending,
        .menuActive, .passwordRequest, .scopeSetting, .ledClearPulse, .relayClearPulse,
        .scadaClearPulse, .tripClearPulse, .ledTestRed, .ledTestGreen);
    front_panel_model #(.OFF_CYC(OFF)) panel_u (.clk_sys, .reset_n, .pressGo, .pressLen,
        .relaySet, .clearKey, .relayOffDelayDone);

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // Match each pulse to oldest note
    always @(negedge clk_sys)
    begin
        if (reset_n && (ledClearPulse | relayClearPulse | scadaClearPulse | tripClearPulse) === 1'b1)
        begin
            if (noteQ.size() == 0)
                check(40'h1, 40'h0);
            else
                check({tripClearPulse, scadaClearPulse, relayClearPulse, ledClearPulse,
                       ledLatched, relayLatched, scadaLatched, tripPending}, noteQ.pop_front());
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic strobe(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : strobe

    task automatic checkState();
        check({4'h0, ledLatched, relayLatched, scadaLatched, tripPending}, {4'h0, st[35:0]});
    endtask : checkState

    task automatic expectClear(input logic [3:0] m, input logic [13:0] keepLed,
                               input logic [7:0] relFree, input logic [5:0] keepTrp);
        st.pul = m;
        if (m[0]) st.led = st.led & keepLed;
        if (m[1]) st.rel = st.rel & ~relFree;
        if (m[2]) st.scd = 8'h00;
        if (m[3]) st.trp = st.trp & keepTrp;
        noteQ.push_back(st);
    endtask : expectClear

    // Pulse sources, wait off-delay
    task automatic latchRandom();
        rnd = $random(seed);
        ledSet = rnd[13:0] | 14'h1;
        relaySet = rnd[21:14];
        scadaSet = rnd[29:22];
        tripSet = {rnd[31:30], 4'hF};
        st[35:0] = st[35:0] | {ledSet, relaySet, scadaSet, tripSet};
        tick(1);
        {ledSet, relaySet, scadaSet, tripSet} = '0;
        tick(OFF + 2);
    endtask : latchRandom

    // Bounded pulse wait; answers passwords
    task automatic drain(input bit pwOk);
        for (int k = 0; k < 60 && noteQ.size() != 0; k++)
        begin
            if (passwordRequest === 1'b1)
            begin
                check({39'h0, pwOk}, 40'h1);
                strobe(passwordValid);
            end
            else
                tick(1);
        end
        if (noteQ.size() != 0)
        begin
            check(40'h1, 40'h0);
            summarize();
        end
        tick(2 * PHASE + 2);
    endtask : drain

    task automatic press(input int len);
        pressLen = 8'(len);
        strobe(pressGo);
        tick(len + 4);
    endtask : press

    initial
    begin
        {paramSetMode, menuOpenNav, softkeyConfirm, softkeyCancel, scopeWrite, pressGo} = '0;
        {passwordValid, first_protection_access_level_empty, clear_all_latched_cmd} = '0;
        {switchgear_trip_clear_cmd, remoteLedClear, remoteRelayClear, remoteScadaClear} = '0;
        {softkeySelect, scopeValue, switchgearSel, pressLen} = '0;
        {ledSet, relaySet, scadaSet, tripSet} = '0;
        remotePermit = 1'b1;
        st = '0;
        tick(20);
        reset_n = 1'b1;
        tick(1);
        check({37'h0, scopeSetting}, {37'h0, ack_ctrl_pkg::SCOPE_RESET});
        checkState();
        latchRandom();
        expectClear(4'hF, 14'h0, 8'hFF, 6'h00);
        strobe(clear_all_latched_cmd);
        drain(1'b1);
        latchRandom();
        ledSet = rnd[13:0] | 14'h1;
        tick(1);
        expectClear(4'hF, ledSet, 8'hFF, 6'h00);
        strobe(clear_all_latched_cmd);
        drain(1'b1);
        ledSet = 14'h0;
        latchRandom();
        remotePermit = 1'b0;
        strobe(clear_all_latched_cmd);
        strobe(remoteLedClear);
        strobe(remoteRelayClear);
        strobe(remoteScadaClear);
        strobe(switchgear_trip_clear_cmd);
        tick(10);
        checkState();
        remotePermit = 1'b1;
        switchgearSel = 8'h02;
        expectClear(4'h8, 14'h0, 8'h00, 6'h3B);
        strobe(switchgear_trip_clear_cmd);
        drain(1'b1);
        switchgearSel = 8'h09;
        strobe(switchgear_trip_clear_cmd);
        tick(8);
        checkState();
        first_protection_access_level_empty = 1'b1;
        relaySet = 8'hF0;
        tick(1);
        relaySet = 8'h00;
        st.rel = st.rel | 8'hF0;
        expectClear(4'h2, 14'h0, 8'h0F, 6'h00);
        strobe(remoteRelayClear);
        drain(1'b0);
        checkState();
        expectClear(4'h2, 14'h0, 8'hFF, 6'h00);
        strobe(remoteRelayClear);
        drain(1'b0);
        first_protection_access_level_empty = 1'b0;
        latchRandom();
        press(3);
        check({39'h0, menuActive}, 40'h1);
        checkState();
        softkeySelect = 4'h5;
        expectClear(4'h5, 14'h0, 8'h00, 6'h00);
        strobe(softkeyConfirm);
        softkeySelect = 4'h0;
        drain(1'b1);
        strobe(softkeyCancel);
        paramSetMode = 1'b1;
        press(3);
        check({39'h0, menuActive}, 40'h0);
        press(HOLD + 3);
        checkState();
        paramSetMode = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            latchRandom();
            scopeValue = 3'(i);
            strobe(scopeWrite);
            check({37'h0, scopeSetting}, 40'(i));
            if (i != 0) expectClear(msk[i], 14'h0, 8'hFF, 6'h00);
            press(HOLD + 3);
            drain(i != 1);
            if (i == 0) check({39'h0, menuActive}, 40'h0);
            checkState();
        end
        scopeValue = 3'h5;
        strobe(scopeWrite);
        tick(1);
        check({37'h0, scopeSetting}, 40'h4);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
